// File: logic/fspc_pkg.sv
// What this block does
// - unprogrammed boot fuse gives reset vector 0x0000, programmed gives boot start
// - software has no write path to any fuse, fuses are read only
// - control/status resets to zero, bit 5 always reads zero
// - ready interrupt asserted while enable, global enable set and enable bit clear
// - erase or write into read-while-write section sets busy flag, blocks section
// - busy flag clears on section re-enable store or buffer word load
// - re-enable request ignored while erase or write still running
// - section-read-enable write aborts buffer loading and drops loaded words
// - lock-set store writes lock bits from low data, ignores rest
// - load in lock-set window returns lock or fuse bits by pointer bit 0
// - page-write store writes buffer into pointer-selected page
// - erase or write into no-read-while-write section halts the core throughout
// - page-erase store erases pointer-selected page
// - enable alone arms four-clock buffer word store, pointer bit 0 ignored
// - enable clears on store end or timeout, held during erase/write
// - only five low-bit patterns accepted, others leave command bits unchanged, bit 7 still written
// - pointer low bits pick word in page, high bits pick page
// - target page latched when an operation starts
// - load addresses bytes, pointer bit 0 picks byte in word
// - buffer clears after page write, re-enable write and reset
// - data EEPROM write blocks flash programming and fuse/lock reads
// - store refused into a section its boot lock protects
package fspc_pkg;
	localparam logic [7:0]  A_CSR = 8'h00;
	localparam logic [7:0]  A_PTR = 8'h04;
	localparam logic [7:0]  A_DAT = 8'h08;
	localparam logic [7:0]  A_INS = 8'h0C;
	localparam logic [7:0]  A_RES = 8'h10;
	localparam logic [7:0]  A_STA = 8'h14;
	localparam int          B_IE = 7;
	localparam int          B_BUSY = 6;
	localparam int          B_RE = 4;
	localparam int          B_EN = 0;
	localparam int          I_STORE = 0;
	localparam int          I_LOAD = 1;
	localparam logic [7:0]  CSR_RST = 8'h00;
	localparam logic [4:0]  P_RE = 5'h11;
	localparam logic [4:0]  P_LS = 5'h09;
	localparam logic [4:0]  P_PW = 5'h05;
	localparam logic [4:0]  P_PE = 5'h03;
	localparam logic [4:0]  P_LD = 5'h01;
	localparam logic [2:0]  STORE_WIN = 3'h4;
	localparam logic [2:0]  LOAD_WIN = 3'h3;
	localparam int          PAGE_WORDS = 64;
	localparam int          WORD_BITS = 6;
	localparam int          PAGE_BITS = 9;
	localparam int          Z_PAGE_LSB = 7;
	localparam logic [8:0]  HALT_FIRST_PAGE = 9'h070;
	localparam logic [8:0]  BOOT_FIRST_PAGE = 9'h078;
	localparam logic [15:0] APP_RESET = 16'h0000;
	localparam logic [15:0] BOOT_START = {1'b0, BOOT_FIRST_PAGE, 6'h00};
	localparam int          L_APP = 2;
	localparam int          L_BOOT = 4;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN   = 2'b11
	} fspc_state_e;
endpackage

// File: logic/fspc_buf_if.sv
`timescale 1ns/1ns
interface fspc_buf_if;
	logic        wr_en;
	logic [5:0]  wr_idx;
	logic [15:0] wr_data;
	logic        clr;
	logic [5:0]  rd_idx;
	logic [15:0] rd_data;
	modport ctl (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data);
	modport mem (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data);
endinterface

// File: logic/fspc_page_buf.sv
`timescale 1ns/1ns
module fspc_page_buf (
	input  wire logic clk,
	input  wire logic sys_rst,
	fspc_buf_if.mem   bus
);
	typedef struct packed {
		logic [fspc_pkg::PAGE_WORDS-1:0][15:0] word;
		logic [fspc_pkg::PAGE_WORDS-1:0]       vld;
		logic [15:0]                           rd;
	} fspc_buf_s;

	fspc_buf_s s;
	fspc_buf_s next_s;

	always_comb
	begin
		next_s = s;
		if (bus.clr)
			next_s.vld = '0;
		else if (bus.wr_en)
		begin
			next_s.word[bus.wr_idx] = bus.wr_data;
			next_s.vld[bus.wr_idx] = 1'b1;
		end
		next_s.rd = s.vld[bus.rd_idx] ? s.word[bus.rd_idx]
			: fspc_pkg::ERASED_WORD;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s.word <= '0;
			s.vld <= '0;
			s.rd <= fspc_pkg::ERASED_WORD;
		end
		else
			s <= next_s;
	end

	assign bus.rd_data = s.rd;
endmodule

// File: logic/fspc_ctrl.sv
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ns
module fspc_ctrl (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        gie,
	input  wire logic        eeprom_busy,
	input  wire logic        boot_reset_fuse,
	input  wire logic [7:0]  fuse_low,
	input  wire logic [7:0]  lock_bits,
	input  wire logic [15:0] flash_rdata,
	input  wire logic        flash_done,
	input  wire logic [5:0]  flash_buf_idx,
	output logic [15:0]      flash_buf_data,
	output logic             flash_erase,
	output logic             flash_write,
	output logic [8:0]       flash_page,
	output logic [14:0]      load_word_addr,
	output logic             lock_we,
	output logic [7:0]       lock_wdata,
	output logic [15:0]      reset_vector,
	output logic             cpu_halt,
	output logic             section_blocked,
	output logic             store_ready_irq
);
	typedef struct packed {
		fspc_pkg::fspc_state_e st;
		logic                  ie;
		logic                  busy;
		logic [4:0]            cmd;
		logic [2:0]            win;
		logic [8:0]            page;
		logic                  halt_sect;
		logic [15:0]           z;
		logic [15:0]           dat;
		logic [7:0]            res;
		logic [31:0]           rdata;
		logic                  rvalid;
		logic                  erase_go;
		logic                  write_go;
		logic                  lock_go;
		logic [7:0]            lock_val;
		logic [8:0]            fmeta;
		logic [8:0]            fuse;
	} fspc_s;

	fspc_s s;
	fspc_s next_s;
	logic  ins_store;
	logic  ins_load;
	logic  buf_wr;
	logic  buf_clr;
	logic  pat_ok;
	logic  lock_ok;
	logic  to_halt;
	logic  [8:0] z_page;

	fspc_buf_if pb ();

	fspc_page_buf u_buf (
		.clk     (clk),
		.sys_rst (sys_rst),
		.bus     (pb.mem)
	);

	assign ins_store = avs_write && avs_address == fspc_pkg::A_INS
		&& avs_writedata[fspc_pkg::I_STORE];
	assign ins_load = avs_write && avs_address == fspc_pkg::A_INS
		&& avs_writedata[fspc_pkg::I_LOAD];
	assign pat_ok = avs_writedata[4:0] == fspc_pkg::P_RE
		|| avs_writedata[4:0] == fspc_pkg::P_LS
		|| avs_writedata[4:0] == fspc_pkg::P_PW
		|| avs_writedata[4:0] == fspc_pkg::P_PE
		|| avs_writedata[4:0] == fspc_pkg::P_LD;
	assign z_page = s.z[15:fspc_pkg::Z_PAGE_LSB];
	assign to_halt = z_page >= fspc_pkg::HALT_FIRST_PAGE;
	assign lock_ok = (z_page >= fspc_pkg::BOOT_FIRST_PAGE)
		? lock_bits[fspc_pkg::L_BOOT] : lock_bits[fspc_pkg::L_APP];

	assign pb.wr_en = buf_wr;
	assign pb.clr = buf_clr;
	assign pb.wr_idx = s.z[fspc_pkg::WORD_BITS:1];
	assign pb.wr_data = s.dat;
	assign pb.rd_idx = flash_buf_idx;

	always_comb
	begin
		next_s = s;
		buf_wr = 1'b0;
		buf_clr = 1'b0;
		// fuses only sampled, never written
		next_s.fmeta = {boot_reset_fuse, fuse_low};
		next_s.fuse = s.fmeta;
		next_s.erase_go = 1'b0;
		next_s.write_go = 1'b0;
		next_s.lock_go = 1'b0;

		// command window
		if (s.st == fspc_pkg::ST_ARMED)
		begin
			if (s.win <= 3'h1)
			begin
				next_s.cmd = 5'h00;
				next_s.win = 3'h0;
				next_s.st = fspc_pkg::ST_IDLE;
			end
			else
				next_s.win = s.win - 3'h1;
		end

		// operation end
		if (s.st == fspc_pkg::ST_RUN && flash_done)
		begin
			next_s.cmd = 5'h00;
			next_s.halt_sect = 1'b0;
			next_s.st = fspc_pkg::ST_IDLE;
			if (s.cmd == fspc_pkg::P_PW)
				buf_clr = 1'b1;
		end

		// register writes
		if (avs_write)
		begin
			case (avs_address)
				fspc_pkg::A_CSR:
				begin
					next_s.ie = avs_writedata[fspc_pkg::B_IE];
					if (s.st != fspc_pkg::ST_RUN && !eeprom_busy
						&& pat_ok)
					begin
						next_s.cmd = avs_writedata[4:0];
						next_s.win = fspc_pkg::STORE_WIN;
						next_s.st = fspc_pkg::ST_ARMED;
						if (avs_writedata[4:0] == fspc_pkg::P_RE)
							buf_clr = 1'b1;
					end
				end
				fspc_pkg::A_PTR:
					next_s.z = avs_writedata[15:0];
				fspc_pkg::A_DAT:
					next_s.dat = avs_writedata[15:0];
				default:
				begin
				end
			endcase
		end

		// store instruction
		if (ins_store && s.st == fspc_pkg::ST_ARMED && !eeprom_busy)
		begin
			next_s.cmd = 5'h00;
			next_s.win = 3'h0;
			next_s.st = fspc_pkg::ST_IDLE;
			case (s.cmd)
				fspc_pkg::P_LD:
				begin
					buf_wr = 1'b1;
					next_s.busy = 1'b0;
				end
				fspc_pkg::P_PE, fspc_pkg::P_PW:
				begin
					if (lock_ok)
					begin
						next_s.page = z_page;
						next_s.halt_sect = to_halt;
						next_s.busy = s.busy | !to_halt;
						next_s.erase_go = s.cmd == fspc_pkg::P_PE;
						next_s.write_go = s.cmd == fspc_pkg::P_PW;
						next_s.cmd = s.cmd;
						next_s.st = fspc_pkg::ST_RUN;
					end
				end
				fspc_pkg::P_LS:
				begin
					next_s.lock_go = 1'b1;
					next_s.lock_val = s.dat[7:0];
				end
				fspc_pkg::P_RE:
				begin
					next_s.busy = 1'b0;
					buf_clr = 1'b1;
				end
				default:
				begin
				end
			endcase
		end

		// load instruction
		if (ins_load)
		begin
			if (s.st == fspc_pkg::ST_ARMED && s.cmd == fspc_pkg::P_LS
				&& s.win > fspc_pkg::STORE_WIN - fspc_pkg::LOAD_WIN
				&& !eeprom_busy)
			begin
				next_s.res = s.z[0] ? lock_bits : s.fuse[7:0];
				next_s.cmd = 5'h00;
				next_s.win = 3'h0;
				next_s.st = fspc_pkg::ST_IDLE;
			end
			else
				next_s.res = s.z[0] ? flash_rdata[15:8]
					: flash_rdata[7:0];
		end

		// register reads, one wait state
		next_s.rvalid = avs_read && !s.rvalid;
		if (avs_read && !s.rvalid)
		begin
			case (avs_address)
				fspc_pkg::A_CSR:
					next_s.rdata = {24'h000000, s.ie, s.busy, 1'b0,
						s.cmd};
				fspc_pkg::A_PTR:
					next_s.rdata = {16'h0000, s.z};
				fspc_pkg::A_DAT:
					next_s.rdata = {16'h0000, s.dat};
				fspc_pkg::A_RES:
					next_s.rdata = {24'h000000, s.res};
				fspc_pkg::A_STA:
					next_s.rdata = {29'h00000000, s.fuse[8], cpu_halt,
						s.st == fspc_pkg::ST_RUN};
				default:
					next_s.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.st <= fspc_pkg::ST_IDLE;
			{s.ie, s.busy, s.cmd} <= fspc_pkg::CSR_RST[7:5] == 3'h0
				? {fspc_pkg::CSR_RST[7:6], fspc_pkg::CSR_RST[4:0]}
				: 7'h00;
		end
		else
			s <= next_s;
	end

	assign avs_waitrequest = avs_read && !s.rvalid;
	assign avs_readdata = s.rdata;
	assign flash_buf_data = pb.rd_data;
	assign flash_erase = s.erase_go;
	assign flash_write = s.write_go;
	assign flash_page = s.page;
	assign load_word_addr = s.z[15:1];
	assign lock_we = s.lock_go;
	assign lock_wdata = s.lock_val;
	assign reset_vector = s.fuse[8] ? fspc_pkg::APP_RESET
		: fspc_pkg::BOOT_START;
	assign cpu_halt = s.st == fspc_pkg::ST_RUN && s.halt_sect;
	assign section_blocked = s.busy;
	assign store_ready_irq = s.ie && gie && !s.cmd[fspc_pkg::B_EN];

	a_reserved_bit_zero: assert property (@(posedge clk) disable iff (sys_rst)
		avs_read && !avs_waitrequest && avs_address == fspc_pkg::A_CSR
		|-> avs_readdata[5] == 1'b0)
		else $error("reserved control bit read as one");

	a_irq_while_idle: assert property (@(posedge clk) disable iff (sys_rst)
		s.ie && gie && s.st == fspc_pkg::ST_IDLE |-> store_ready_irq)
		else $error("ready interrupt missing while enable bit clear");

	a_busy_on_section: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(s.st == fspc_pkg::ST_RUN) && !s.halt_sect
		|-> section_blocked && (flash_erase || flash_write))
		else $error("section busy not set on operation start");

	a_halt_on_op: assert property (@(posedge clk) disable iff (sys_rst)
		(flash_erase || flash_write) && s.halt_sect
		|-> cpu_halt until flash_done)
		else $error("core not halted during protected section operation");

	a_window_expires: assert property (@(posedge clk) disable iff (sys_rst)
		(s.st == fspc_pkg::ST_ARMED && !avs_write) [*4]
		|=> s.st == fspc_pkg::ST_IDLE && !s.cmd[0])
		else $error("enable bit outlived its four clock window");

	a_bad_pattern: assert property (@(posedge clk) disable iff (sys_rst)
		avs_write && avs_address == fspc_pkg::A_CSR && !pat_ok
		&& s.st == fspc_pkg::ST_IDLE
		|=> s.st == fspc_pkg::ST_IDLE && s.cmd == 5'h00)
		else $error("invalid control pattern took effect");

	a_lock_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		ins_store && s.st == fspc_pkg::ST_ARMED && s.cmd == fspc_pkg::P_LS
		&& !eeprom_busy
		|=> lock_we && lock_wdata == $past(s.dat[7:0]) ##1 !lock_we)
		else $error("lock write pulse wrong");

	a_page_latched: assert property (@(posedge clk) disable iff (sys_rst)
		s.st == fspc_pkg::ST_RUN && !flash_done
		|=> $stable(flash_page))
		else $error("page moved during operation");

	a_eeprom_blocks: assert property (@(posedge clk) disable iff (sys_rst)
		eeprom_busy |=> !flash_erase && !flash_write && !lock_we)
		else $error("programming started during data EEPROM write");
endmodule

// File: verification/fspc_flash_model.sv
`timescale 1ns/1ns
module fspc_flash_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        flash_erase,
	input  wire logic        flash_write,
	input  wire logic [14:0] load_word_addr,
	input  wire logic        lock_we,
	input  wire logic [7:0]  lock_wdata,
	input  wire logic [15:0] flash_buf_data,
	output logic             flash_done,
	output logic [15:0]      flash_rdata,
	output logic [5:0]       flash_buf_idx,
	output logic [7:0]       lock_bits
);
	logic [15:0] mem [64];
	logic [7:0]  cnt;
	logic        busy;
	assign flash_rdata = {load_word_addr[7:0], 8'hC3} ^ 16'h0F0F;
	assign flash_buf_idx = cnt[5:0];
	// array walks the buffer, then ends the operation with a pulse
	always_ff @(posedge clk)
	begin
		flash_done <= 1'b0;
		if (sys_rst)
		begin
			busy <= 1'b0;
			cnt <= 8'h00;
			lock_bits <= 8'hFF;
		end
		else if (flash_erase || flash_write)
		begin
			busy <= 1'b1;
			cnt <= 8'h00;
		end
		else if (busy)
		begin
			cnt <= cnt + 8'h01;
			if (cnt > 8'h00 && cnt <= 8'h40)
				mem[cnt[5:0] - 6'h01] <= flash_buf_data;
			if (cnt == 8'h44)
			begin
				flash_done <= 1'b1;
				busy <= 1'b0;
			end
		end
		if (lock_we)
			lock_bits <= lock_bits & lock_wdata;
	end
endmodule

// File: verification/test_flash_self_program_control.sv
`timescale 1ns/1ns
module test_flash_self_program_control;
	logic        clk, sys_rst, avs_read, avs_write, gie, eeprom_busy;
	logic        boot_reset_fuse, flash_done, flash_erase, flash_write;
	logic        lock_we, cpu_halt, section_blocked, store_ready_irq;
	logic        avs_waitrequest;
	logic [7:0]  avs_address, fuse_low, lock_bits, lock_wdata, seen_lock;
	logic [31:0] avs_writedata, avs_readdata, seed, q[$];
	logic [15:0] flash_rdata, flash_buf_data, reset_vector, d, w, z;
	logic [5:0]  flash_buf_idx;
	logic [8:0]  flash_page, seen_pg;
	logic [14:0] load_word_addr;
	int          fails, n_checks, t;
	fspc_ctrl fspc_ctrl_i (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.gie(gie), .eeprom_busy(eeprom_busy),
		.boot_reset_fuse(boot_reset_fuse), .fuse_low(fuse_low),
		.lock_bits(lock_bits), .flash_rdata(flash_rdata),
		.flash_done(flash_done), .flash_buf_idx(flash_buf_idx),
		.flash_buf_data(flash_buf_data), .flash_erase(flash_erase),
		.flash_write(flash_write), .flash_page(flash_page),
		.load_word_addr(load_word_addr), .lock_we(lock_we),
		.lock_wdata(lock_wdata), .reset_vector(reset_vector),
		.cpu_halt(cpu_halt), .section_blocked(section_blocked),
		.store_ready_irq(store_ready_irq));
	fspc_flash_model fspc_flash_model_i (.clk(clk), .sys_rst(sys_rst),
		.flash_erase(flash_erase), .flash_write(flash_write),
		.load_word_addr(load_word_addr), .lock_we(lock_we),
		.lock_wdata(lock_wdata), .flash_buf_data(flash_buf_data),
		.flash_done(flash_done), .flash_rdata(flash_rdata),
		.flash_buf_idx(flash_buf_idx), .lock_bits(lock_bits));
	always #4 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	// interrupt enable kept set, every control write also writes bit 7
	task automatic csr(input logic [7:0] v);
		wr(fspc_pkg::A_CSR, {24'h0, v | 8'h80});
	endtask
	task automatic store_ins;
		wr(fspc_pkg::A_INS, 32'h1);
	endtask
	task automatic load_ins;
		wr(fspc_pkg::A_INS, 32'h2);
	endtask
	task automatic wait_done;
		int i;
		for (i = 0; i < 300 && flash_done !== 1'b1; i++)
			@(posedge clk);
		if (i >= 300)
			fails++;
		@(posedge clk);
	endtask
	task automatic endt;
		$display("test %0d done", t);
		t++;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// read results against the oldest noted expectation
	always @(posedge clk)
	begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk(avs_readdata, q.pop_front());
		if (flash_erase === 1'b1 || flash_write === 1'b1)
			seen_pg <= flash_page;
		if (lock_we === 1'b1)
			seen_lock <= lock_wdata;
	end
	initial
	begin
		#160000;
		fails++;
		wrap_up();
	end
	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{avs_read, avs_write, eeprom_busy, avs_address} = '0;
		avs_writedata = '0;
		gie = 1'b1;
		boot_reset_fuse = 1'b1;
		seed = lfsr(32'hf636d5af);
		fuse_low = seed[7:0];
		t = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(reset_vector, fspc_pkg::APP_RESET);
		rd(fspc_pkg::A_CSR, 32'h00);
		csr(8'hFF);
		rd(fspc_pkg::A_CSR, 32'h80);
		chk(store_ready_irq, 1'b1);
		gie <= 1'b0;
		@(posedge clk);
		chk(store_ready_irq, 1'b0);
		gie <= 1'b1;
		endt();
		seed = lfsr(seed);
		d = seed[15:0];
		wr(fspc_pkg::A_PTR, 32'h0285);
		wr(fspc_pkg::A_DAT, {16'h0, d});
		csr(8'h01);
		store_ins();
		rd(fspc_pkg::A_CSR, 32'h80);
		wr(fspc_pkg::A_PTR, 32'h0280);
		csr(8'h03);
		store_ins();
		wr(fspc_pkg::A_PTR, 32'h0000);
		rd(fspc_pkg::A_CSR, 32'hC3);
		chk(seen_pg, 9'h005);
		chk(flash_page, 9'h005);
		chk({section_blocked, cpu_halt, store_ready_irq}, 3'b100);
		csr(8'h11);
		rd(fspc_pkg::A_CSR, 32'hC3);
		wait_done();
		rd(fspc_pkg::A_CSR, 32'hC0);
		endt();
		wr(fspc_pkg::A_PTR, 32'h0280);
		csr(8'h05);
		store_ins();
		wait_done();
		chk(fspc_flash_model_i.mem[2], d);
		chk(fspc_flash_model_i.mem[3], 16'hFFFF);
		csr(8'h11);
		store_ins();
		rd(fspc_pkg::A_CSR, 32'h80);
		chk(section_blocked, 1'b0);
		wr(fspc_pkg::A_PTR, 32'h0286);
		csr(8'h01);
		store_ins();
		csr(8'h11);
		wr(fspc_pkg::A_PTR, 32'h0280);
		csr(8'h05);
		store_ins();
		wait_done();
		chk(fspc_flash_model_i.mem[3], 16'hFFFF);
		chk(fspc_flash_model_i.mem[2], 16'hFFFF);
		csr(8'h01);
		store_ins();
		rd(fspc_pkg::A_CSR, 32'h80);
		endt();
		wr(fspc_pkg::A_PTR, 32'h3800);
		csr(8'h03);
		store_ins();
		@(posedge clk);
		chk({cpu_halt, seen_pg}, {1'b1, 9'h070});
		wait_done();
		chk(cpu_halt, 1'b0);
		wr(fspc_pkg::A_DAT, 32'hAAE3);
		csr(8'h09);
		store_ins();
		@(posedge clk);
		chk(seen_lock, 8'hE3);
		rd(fspc_pkg::A_CSR, 32'h80);
		wr(fspc_pkg::A_PTR, 32'h0280);
		csr(8'h03);
		store_ins();
		rd(fspc_pkg::A_CSR, 32'h80);
		chk(section_blocked, 1'b0);
		endt();
		for (int i = 0; i < 2; i++)
		begin
			wr(fspc_pkg::A_PTR, i);
			csr(8'h09);
			load_ins();
			rd(fspc_pkg::A_RES, i ? 32'hE3 : {24'h0, fuse_low});
		end
		eeprom_busy <= 1'b1;
		csr(8'h09);
		rd(fspc_pkg::A_CSR, 32'h80);
		eeprom_busy <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			z = 16'h0122 | i;
			w = {z[8:1], 8'hC3} ^ 16'h0F0F;
			wr(fspc_pkg::A_PTR, {16'h0, z});
			load_ins();
			rd(fspc_pkg::A_RES, i ? w[15:8] : w[7:0]);
		end
		csr(8'h01);
		repeat (6) @(posedge clk);
		rd(fspc_pkg::A_CSR, 32'h80);
		rd(8'h20, 32'h0);
		boot_reset_fuse <= 1'b0;
		repeat (3) @(posedge clk);
		chk(reset_vector, fspc_pkg::BOOT_START);
		endt();
		wrap_up();
	end
endmodule
